/* core/psf_pkg.sv */
// Constants, field positions and types for the port power status flags.
// Assumes one 10 MHz clock and a synchronous active-low reset.
// Notes on behaviour
// - Misc bit 5 mirrors interrupt line drive
// - Misc bit 4 mirrors attach-detect line drive
// - Misc bit 3 follows charge current threshold
// - Charge and emulation flags may cycle freely
// - Misc bit 2: active state and emulating
// - Pair index: 00 none, 01, 10, 11
// - Two-pair profiles never report pair three
// - Attach mirror may toggle on bypass overload
// - Fault latch sets on entering error state
// - Writing latch zero rechecks all fault conditions
// - Error state held while fault bits set, except on host latch zero or power disable
// - Auto-recovery or power disable clears latch
// - Interrupt line independent of fault latch
// - Bit 6 discharge failure, interrupt, error
// - Fault flags read-clear once removed, latch-clear
// - Bit 5 power-up flag, silent, read-cleared
// - Bit 3 thermal shutdown, interrupt, error
// - Bit 2 supply overvoltage, interrupt, error
// - Bit 1 back voltage, interrupt, error
// - Bit 0 overcurrent, interrupt, error
`default_nettype none

package psf_pkg;
    // Register offsets on the management port
    localparam logic [7:0] MISC_OFS = 8'h0f;
    localparam logic [7:0] FAULT_OFS = 8'h10;
    localparam logic [7:0] EVENT_OFS = 8'h11;
    localparam logic [7:0] PROF_A_OFS = 8'h12;
    localparam logic [7:0] PROF_B_OFS = 8'h13;
    localparam logic [7:0] PIN_OFS = 8'h14;
    // Reset values; the power-up flag starts set
    localparam logic [7:0] MISC_RST = 8'h00;
    localparam logic [7:0] FAULT_RST = 8'h20;
    localparam logic [7:0] RDATA_RST = 8'h00;
    // Misc status field positions
    localparam int MISC_ALERT_BIT = 5;
    localparam int MISC_ATTACH_BIT = 4;
    localparam int MISC_CHG_BIT = 3;
    localparam int MISC_EMU_BIT = 2;
    // Fault status field positions
    localparam int FAULT_LATCH_BIT = 7;
    localparam int FAULT_DISCH_BIT = 6;
    localparam int FAULT_POR_BIT = 5;
    localparam int FAULT_VLOW_BIT = 4;
    localparam int FAULT_TSD_BIT = 3;
    localparam int FAULT_SOV_BIT = 2;
    localparam int FAULT_BACK_BIT = 1;
    localparam int FAULT_OCUR_BIT = 0;
    // Bits that carry a live fault condition
    localparam logic [7:0] COND_MASK = 8'h5f;
    // Pair index codes
    localparam logic [1:0] PAIR_NONE = 2'h0;
    localparam logic [1:0] PAIR_THREE = 2'h3;

    // Inputs from outside the clock domain, after two flops
    typedef struct packed {
        logic disch;     // Bus discharge failed
        logic vbus_low;  // Bus below minimum
        logic thermal;   // Die over shutdown threshold
        logic supply_ov; // Source supply over threshold
        logic back_v;    // Bus above a supply by margin
        logic overcur;   // Current over limit and region two
        logic chg;       // Current over charge activity threshold
        logic emu;       // Emulation profile being applied
        logic [1:0] pair; // Pair being applied
        logic two_pair;  // Applied profile uses two pairs only
        logic ppe;       // Port power enable
        logic auto_rec;  // Auto-recovery fault handling
        logic attach;    // Attach detection wants the line low
    } psf_in_t;

    localparam int SYNC_W = $bits(psf_in_t);

    // Device state as seen by the fault logic
    typedef enum logic {PSF_ACTIVE, PSF_ERROR} psf_state_t;
endpackage : psf_pkg

`default_nettype wire

/* core/psf_sync_if.sv */
// Carrier between the status top and its input synchroniser.
// Assumes both ends run on the same clock.
`default_nettype none

interface psf_sync_if;
    logic [psf_pkg::SYNC_W-1:0] raw;  // Asynchronous levels
    logic [psf_pkg::SYNC_W-1:0] sync; // Levels after two flops
    modport src (output raw, input sync);
    modport sink (input raw, output sync);
endinterface : psf_sync_if

`default_nettype wire

/* core/psf_sync.sv */
// Two-flop synchroniser for every asynchronous status input.
// Assumes inputs are slow levels; no event shorter than two clocks.
`default_nettype none

module psf_sync (
    input wire logic clock_i,
    input wire logic rst_b_i,
    psf_sync_if.sink sif
);
    // First stage only feeds the second, never any logic
    logic [psf_pkg::SYNC_W-1:0] meta_ff;
    logic [psf_pkg::SYNC_W-1:0] sync_ff;

    genvar gi;
    generate
        for (gi = 0; gi < psf_pkg::SYNC_W; gi++) begin : g_bit
            // One chain per bit keeps the stages side by side
            always_ff @(posedge clock_i) begin
                if (!rst_b_i) begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                end else begin
                    meta_ff[gi] <= sif.raw[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate

    assign sif.sync = sync_ff;
endmodule : psf_sync

`default_nettype wire

/* core/psf_status.sv */
// Status flags of the port power controller: misc and fault registers.
// Assumes the serial slave delivers one-cycle decoded read and write
// strobes on clock_i; analog condition inputs are asynchronous levels.
`default_nettype none

module psf_status (
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Decoded management port access, same clock domain
    input wire logic reg_rd_i,        // Completed read of reg_addr_i
    input wire logic reg_wr_i,        // Completed write
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,   // Valid the cycle after reg_rd_i
    // Asynchronous condition inputs
    input wire logic discharge_fail_i,
    input wire logic vbus_low_i,
    input wire logic thermal_shutdown_i,
    input wire logic supply_overvoltage_i,
    input wire logic back_voltage_i,
    input wire logic overcurrent_i,
    input wire logic charge_activity_i,
    input wire logic emulation_running_i,
    input wire logic [1:0] pair_index_i,
    input wire logic two_pair_profile_i,
    input wire logic port_power_enable_i,
    input wire logic auto_recovery_i,
    input wire logic attach_request_i,
    // Open-drain lines: enable high pulls the line low
    output logic interrupt_line_oe_o,
    output logic attach_detect_line_oe_o,
    output logic error_state_o
);
    // Synchronised view of every pin input
    psf_sync_if sif ();
    psf_pkg::psf_in_t s;

    psf_sync u_sync (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .sif(sif.sink)
    );

    assign sif.raw = {discharge_fail_i, vbus_low_i, thermal_shutdown_i,
                      supply_overvoltage_i, back_voltage_i, overcurrent_i,
                      charge_activity_i, emulation_running_i, pair_index_i,
                      two_pair_profile_i, port_power_enable_i,
                      auto_recovery_i, attach_request_i};
    assign s = sif.sync;

    // Address match, used by read and write decode alike
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // State
    psf_pkg::psf_state_t state_ff, nxt_state;
    logic [7:0] fault_ff, nxt_fault;     // Fault status register
    logic alert_ff, nxt_alert;           // Interrupt line drive
    logic attach_ff, nxt_attach;         // Attach line drive
    logic ppe_prev_ff, nxt_ppe_prev;     // Last port power enable
    logic [7:0] rdata_ff, nxt_rdata;     // Read data holding register

    // Decoded events
    logic [7:0] cond8;       // Live conditions placed at fault bits
    logic any_cond;
    logic rd_fault;
    logic wr_err0;
    logic ppe_fall;
    logic clear_latch;
    logic [1:0] pair_rep;
    logic [7:0] misc_val;

    // Conditions lined up with their flag positions
    always_comb begin
        cond8 = 8'h00;
        cond8[psf_pkg::FAULT_DISCH_BIT] = s.disch;
        cond8[psf_pkg::FAULT_VLOW_BIT] = s.vbus_low;
        cond8[psf_pkg::FAULT_TSD_BIT] = s.thermal;
        cond8[psf_pkg::FAULT_SOV_BIT] = s.supply_ov;
        cond8[psf_pkg::FAULT_BACK_BIT] = s.back_v;
        cond8[psf_pkg::FAULT_OCUR_BIT] = s.overcur;
        any_cond = |cond8;
    end

    // Access decode; reads, latch-zero writes, power disable and auto-recovery may clear
    always_comb begin
        rd_fault = reg_rd_i && hit(reg_addr_i, psf_pkg::FAULT_OFS);
        // Only a zero in the latch bit acts; other writes vanish
        wr_err0 = reg_wr_i && hit(reg_addr_i, psf_pkg::FAULT_OFS)
                  && !reg_wdata_i[psf_pkg::FAULT_LATCH_BIT];
        ppe_fall = ppe_prev_ff && !s.ppe;
        // Latch release: power off, host zero with all clear, or auto
        clear_latch = !s.ppe
            || (wr_err0 && !any_cond)
            || (s.auto_rec && !any_cond
                && ((fault_ff & psf_pkg::COND_MASK) == 8'h00));
    end

    // Fault register next value; sets are applied last so they win
    always_comb begin
        nxt_fault = fault_ff;
        if (rd_fault) begin
            // Drop only flags whose condition has gone
            nxt_fault = nxt_fault & ~(psf_pkg::COND_MASK & ~cond8);
            nxt_fault[psf_pkg::FAULT_POR_BIT] = 1'b0;
        end
        if (ppe_fall) begin
            nxt_fault[psf_pkg::FAULT_POR_BIT] = 1'b0;
        end
        if (clear_latch) begin
            // Latch clear takes every condition flag with it
            nxt_fault = nxt_fault & ~psf_pkg::COND_MASK;
            nxt_fault[psf_pkg::FAULT_LATCH_BIT] = 1'b0;
        end
        // A present condition re-sets its flag and the latch
        nxt_fault = nxt_fault | cond8;
        if (any_cond) begin
            nxt_fault[psf_pkg::FAULT_LATCH_BIT] = 1'b1;
        end
        // Error state follows the latch alone, not the other flags
        if (nxt_fault[psf_pkg::FAULT_LATCH_BIT]) begin
            nxt_state = psf_pkg::PSF_ERROR;
        end else begin
            nxt_state = psf_pkg::PSF_ACTIVE;
        end
        // Interrupt line from condition flags only, never the
        // power-up flag nor the latch itself
        nxt_alert = |(nxt_fault & psf_pkg::COND_MASK);
        nxt_attach = s.attach;  // Overload may make this toggle
        nxt_ppe_prev = s.ppe;
    end

    // Misc status view and read data
    always_comb begin
        // Two-pair profiles cannot show pair three
        pair_rep = (s.two_pair && s.pair == psf_pkg::PAIR_THREE) ?
                   psf_pkg::PAIR_NONE : s.pair;
        misc_val = psf_pkg::MISC_RST;
        misc_val[psf_pkg::MISC_ALERT_BIT] = alert_ff;
        misc_val[psf_pkg::MISC_ATTACH_BIT] = attach_ff;
        // Raw level: may cycle during emulation cycling
        misc_val[psf_pkg::MISC_CHG_BIT] = s.chg;
        misc_val[psf_pkg::MISC_EMU_BIT] = s.emu
            && (state_ff == psf_pkg::PSF_ACTIVE);
        misc_val[1:0] = pair_rep;
        nxt_rdata = rdata_ff;
        if (reg_rd_i) begin
            // Unmapped and out-of-scope registers read zero
            if (hit(reg_addr_i, psf_pkg::MISC_OFS)) begin
                nxt_rdata = misc_val;
            end else if (hit(reg_addr_i, psf_pkg::FAULT_OFS)) begin
                nxt_rdata = fault_ff;
            end else begin
                nxt_rdata = psf_pkg::RDATA_RST;
            end
        end
    end

    // Registers
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            state_ff <= psf_pkg::PSF_ACTIVE;
            fault_ff <= psf_pkg::FAULT_RST;
            alert_ff <= 1'b0;
            attach_ff <= 1'b0;
            ppe_prev_ff <= 1'b0;
            rdata_ff <= psf_pkg::RDATA_RST;
        end else begin
            state_ff <= nxt_state;
            fault_ff <= nxt_fault;
            alert_ff <= nxt_alert;
            attach_ff <= nxt_attach;
            ppe_prev_ff <= nxt_ppe_prev;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign interrupt_line_oe_o = alert_ff;
    assign attach_detect_line_oe_o = attach_ff;
    assign error_state_o = (state_ff == psf_pkg::PSF_ERROR);

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    logic rd_misc;
    assign rd_misc = reg_rd_i && hit(reg_addr_i, psf_pkg::MISC_OFS);

    sequence s_misc_read;
        rd_misc;
    endsequence
    sequence s_clear_req;
        rd_fault && !cond8[psf_pkg::FAULT_OCUR_BIT] && !clear_latch;
    endsequence

    property p_alert_bit;
        s_misc_read |=> reg_rdata_o[5] == $past(alert_ff);
    endproperty
    a_alert_bit: assert property (p_alert_bit)
        else $error("alert mirror bit wrong");

    property p_attach_bit;
        s_misc_read |=> reg_rdata_o[4] == $past(attach_ff);
    endproperty
    a_attach_bit: assert property (p_attach_bit)
        else $error("attach mirror bit wrong");

    property p_chg_bit;
        s_misc_read |=> reg_rdata_o[3] == $past(s.chg);
    endproperty
    a_chg_bit: assert property (p_chg_bit)
        else $error("charge flag wrong");

    property p_emu_bit;
        s_misc_read and state_ff == psf_pkg::PSF_ERROR
            |=> !reg_rdata_o[2] && reg_rdata_o[7:6] == 2'h0;
    endproperty
    a_emu_bit: assert property (p_emu_bit)
        else $error("emulation flag set outside active state");

    property p_two_pair;
        s_misc_read and s.two_pair |=> reg_rdata_o[1:0] != 2'h3;
    endproperty
    a_two_pair: assert property (p_two_pair)
        else $error("pair three shown for two-pair profile");

    property p_latch_set;
        any_cond |=> fault_ff[7] && state_ff == psf_pkg::PSF_ERROR;
    endproperty
    a_latch_set: assert property (p_latch_set)
        else $error("latch not set on fault");

    property p_host_clear;
        wr_err0 && !any_cond |=> !fault_ff[7]
            && state_ff == psf_pkg::PSF_ACTIVE && fault_ff[4:0] == 5'h00;
    endproperty
    a_host_clear: assert property (p_host_clear)
        else $error("host clear did not return to active");

    property p_hold_error;
        state_ff == psf_pkg::PSF_ERROR && (fault_ff & 8'h5f) != 8'h00
            && s.ppe && !wr_err0 |=> state_ff == psf_pkg::PSF_ERROR;
    endproperty
    a_hold_error: assert property (p_hold_error)
        else $error("left error state with flags set");

    property p_power_off;
        !s.ppe && !any_cond |=> !fault_ff[7] && !alert_ff;
    endproperty
    a_power_off: assert property (p_power_off)
        else $error("power disable did not clear latch");

    property p_disch;
        cond8[6] |=> fault_ff[6] && alert_ff
            && state_ff == psf_pkg::PSF_ERROR;
    endproperty
    a_disch: assert property (p_disch)
        else $error("discharge fault did not raise interrupt");

    property p_read_clear;
        s_clear_req |=> !fault_ff[0];
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("read did not clear removed flag");

    property p_flag_set;
        any_cond |=> (fault_ff & $past(cond8)) == $past(cond8) && alert_ff;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("condition flag or interrupt missing");

    property p_latch_flags;
        clear_latch && !any_cond
            |=> (fault_ff & psf_pkg::COND_MASK) == 8'h00 && !fault_ff[7];
    endproperty
    a_latch_flags: assert property (p_latch_flags)
        else $error("latch clear left a condition flag");

    property p_auto_rec;
        s.auto_rec && !any_cond && (fault_ff & psf_pkg::COND_MASK) == 8'h00
            |=> !fault_ff[7] && state_ff == psf_pkg::PSF_ACTIVE;
    endproperty
    a_auto_rec: assert property (p_auto_rec)
        else $error("auto-recovery did not leave error state");

    property p_pair_code;
        s_misc_read and !s.two_pair |=> reg_rdata_o[1:0] == $past(s.pair);
    endproperty
    a_pair_code: assert property (p_pair_code)
        else $error("pair index field wrong");

    property p_por_clear;
        rd_fault || ppe_fall |=> !fault_ff[psf_pkg::FAULT_POR_BIT];
    endproperty
    a_por_clear: assert property (p_por_clear)
        else $error("power-up flag not cleared");

    property p_por_silent;
        (fault_ff & psf_pkg::COND_MASK) == 8'h00 |-> !interrupt_line_oe_o;
    endproperty
    a_por_silent: assert property (p_por_silent)
        else $error("interrupt line without a condition flag");

    property p_unmapped_read;
        reg_rd_i && !rd_misc && !rd_fault |=> reg_rdata_o == psf_pkg::RDATA_RST;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped register read not zero");
endmodule : psf_status

`default_nettype wire

/* sim/psf_host_model.sv */
// Host model that reads and writes the status block over its decoded
// strobe port. Assumes one caller at a time and the block's clock.
`default_nettype none

module psf_host_model (
    input wire logic clock_i,
    input wire logic [7:0] reg_rdata_i,
    output logic reg_rd_o,
    output logic reg_wr_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus at time zero
    initial begin
        reg_rd_o = 1'b0;
        reg_wr_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end

    // One read strobe; data taken after the answering edge settles
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_rd_o <= 1'b1;
        reg_addr_o <= a;
        @(posedge clock_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a; // Released lines show no stale value
        @(negedge clock_i);
        d = reg_rdata_i;
    endtask : rd

    // One write strobe; a zero to the latch bit clears it when no condition is live
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_wr_o <= 1'b1;
        reg_addr_o <= a;
        reg_wdata_o <= d;
        @(posedge clock_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask : wr
endmodule : psf_host_model

`default_nettype wire

/* sim/test_port_power_status_flags.sv */
// Self-checking bench for the misc and fault status registers.
// Assumes a 10 MHz clock and the host model as the only bus master.
`default_nettype none

module test_port_power_status_flags;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic rd, wr, int_oe, att_oe, err_st;
    logic [7:0] addr, wdata, rdata, fb;
    logic [5:0] cond = 6'h00; // Fault inputs, bit 5 is discharge
    logic chg = 1'b0, emu = 1'b0, tp = 1'b0, att = 1'b0;
    logic ppe = 1'b1, auto_r = 1'b0; // Power starts enabled
    logic [1:0] pair = 2'h0;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    psf_status DUT (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .reg_rd_i(rd),
        .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .discharge_fail_i(cond[5]),
        .vbus_low_i(cond[4]), .thermal_shutdown_i(cond[3]),
        .supply_overvoltage_i(cond[2]), .back_voltage_i(cond[1]),
        .overcurrent_i(cond[0]), .charge_activity_i(chg),
        .emulation_running_i(emu), .pair_index_i(pair),
        .two_pair_profile_i(tp), .port_power_enable_i(ppe),
        .auto_recovery_i(auto_r), .attach_request_i(att),
        .interrupt_line_oe_o(int_oe), .attach_detect_line_oe_o(att_oe),
        .error_state_o(err_st)
    );

    psf_host_model host (
        .clock_i(clock_i), .reg_rdata_i(rdata), .reg_rd_o(rd),
        .reg_wr_o(wr), .reg_addr_o(addr), .reg_wdata_o(wdata)
    );

    // Free-running 100 ns clock
    initial begin
        forever #50 clock_i = ~clock_i;
    end

    // Hang guard: the tests need well under a thousand cycles
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            $display("[ERR] %0t timeout", $time);
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // Byte comparison; four-state equality so unknowns fail
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t byte got %h exp %h", $time, g, e);
        end
    endtask : chk8

    // Single flag comparison, sampled off the clock edge
    task automatic chk1(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t flag got %b exp %b", $time, g, e);
        end
    endtask : chk1

    // Read a register and compare with the expected byte
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk8(d, e);
    endtask : rd_chk

    // Let the two-flop input path and the flag update land
    task automatic settle();
        repeat (5) @(posedge clock_i);
        @(negedge clock_i);
    endtask : settle

    // Drive the misc-status inputs in one go
    task automatic set_misc(input logic c, input logic e,
                            input logic [1:0] p, input logic t,
                            input logic a);
        @(posedge clock_i);
        chg <= c;
        emu <= e;
        pair <= p;
        tp <= t;
        att <= a;
        settle();
    endtask : set_misc

    initial begin
        repeat (8) @(posedge clock_i);
        rst_b_i <= 1'b1;
        // Reset values, power-up flag and read-only places
        rd_chk(8'h0f, 8'h00);
        rd_chk(8'h10, 8'h20);
        rd_chk(8'h10, 8'h00);
        rd_chk(8'h11, 8'h00);
        rd_chk(8'h20, 8'h00);
        $display("test reset done");
        // Misc mirrors and pair codes
        set_misc(1'b1, 1'b1, 2'h1, 1'b0, 1'b1);
        chk1(att_oe, 1'b1);
        rd_chk(8'h0f, 8'h1d);
        set_misc(1'b1, 1'b1, 2'h2, 1'b0, 1'b1);
        rd_chk(8'h0f, 8'h1e);
        set_misc(1'b1, 1'b1, 2'h3, 1'b0, 1'b1);
        rd_chk(8'h0f, 8'h1f);
        set_misc(1'b1, 1'b1, 2'h3, 1'b1, 1'b1);
        rd_chk(8'h0f, 8'h1c);
        host.wr(8'h0f, 8'hff);
        rd_chk(8'h0f, 8'h1c);
        set_misc(1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
        rd_chk(8'h0f, 8'h00);
        $display("test misc done");
        // Every fault source in latched handling
        for (int i = 0; i < 6; i++) begin
            fb = (i == 5) ? 8'h40 : (8'h01 << i);
            @(posedge clock_i);
            cond <= 6'h01 << i;
            settle();
            chk1(err_st, 1'b1);
            chk1(int_oe, 1'b1);
            rd_chk(8'h0f, 8'h20);
            rd_chk(8'h10, 8'h80 | fb);
            rd_chk(8'h10, 8'h80 | fb);
            host.wr(8'h10, 8'h00);
            settle();
            chk1(err_st, 1'b1);
            @(posedge clock_i);
            cond <= 6'h00;
            settle();
            chk1(err_st, 1'b1);
            rd_chk(8'h10, 8'h80 | fb);
            chk1(int_oe, 1'b0);
            chk1(err_st, 1'b1);
            rd_chk(8'h10, 8'h80);
            host.wr(8'h10, 8'h00);
            settle();
            chk1(err_st, 1'b0);
            rd_chk(8'h10, 8'h00);
        end
        $display("test faults done");
        // Auto-recovery; emulation flag is held off while in error
        @(posedge clock_i);
        auto_r <= 1'b1;
        emu <= 1'b1;
        cond <= 6'h08;
        settle();
        rd_chk(8'h0f, 8'h20);
        @(posedge clock_i);
        cond <= 6'h00;
        settle();
        chk1(err_st, 1'b1);
        rd_chk(8'h10, 8'h88);
        settle();
        chk1(err_st, 1'b0);
        rd_chk(8'h0f, 8'h04);
        rd_chk(8'h10, 8'h00);
        $display("test auto done");
        // Port power disable drops the latch and its flag
        @(posedge clock_i);
        auto_r <= 1'b0;
        emu <= 1'b0;
        cond <= 6'h01;
        settle();
        @(posedge clock_i);
        cond <= 6'h00;
        settle();
        chk1(err_st, 1'b1);
        @(posedge clock_i);
        ppe <= 1'b0;
        settle();
        chk1(err_st, 1'b0);
        rd_chk(8'h10, 8'h00);
        @(posedge clock_i);
        ppe <= 1'b1;
        $display("test power done");
        // Mid-run reset sets the power-up flag; a power toggle drops it
        @(posedge clock_i);
        rst_b_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        rst_b_i <= 1'b1;
        settle();
        chk1(err_st, 1'b0);
        chk1(int_oe, 1'b0);
        @(posedge clock_i);
        ppe <= 1'b0;
        settle();
        @(posedge clock_i);
        ppe <= 1'b1;
        settle();
        rd_chk(8'h10, 8'h00);
        $display("test toggle done");
        tally_and_finish();
    end
endmodule : test_port_power_status_flags

`default_nettype wire
